// File: hw/gpc_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_pin_cell #(
   parameter bit IMPL = 1'b1
) (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Configuration
   input  wire logic [1:0] mode_bits_i,
   input  wire logic       latch_i,
   input  wire logic       pull_sel_i,
   input  wire logic       in_disable_i,
   // Peripheral override
   input  wire logic       fn_claim_i,
   input  wire logic       fn_out_i,
   input  wire logic       fn_oe_i,
   // Pad
   input  wire logic       pad_in_i,
   output logic            pad_out_o,
   output logic            pad_oe_n_o,
   output logic            pull_up_o,
   output logic            pull_down_o,
   output logic            din_o
);
   import gpc_pkg::*;

   gpc_mode_t mode;
   logic      drive_val;
   logic      drive_on;
   logic      next_out;
   logic      next_oe_n;
   logic      next_up;
   logic      next_down;

   always_comb begin
      case (mode_bits_i)
         MODE_BITS_HIZ:  mode = GPC_MODE_HIZ;
         MODE_BITS_PULL: mode = GPC_MODE_PULL;
         MODE_BITS_PP:   mode = GPC_MODE_PP;
         MODE_BITS_OD:   mode = GPC_MODE_OD;
         default:        mode = GPC_MODE_HIZ;
      endcase
   end

   // A claiming peripheral owns data and direction; pad style stays
   assign drive_val = fn_claim_i ? fn_out_i : latch_i;
   assign drive_on  = fn_claim_i ? fn_oe_i :
                      (mode == GPC_MODE_PP || mode == GPC_MODE_OD);

   always_comb begin
      next_out  = 1'b0;
      next_oe_n = 1'b1;
      next_up   = 1'b0;
      next_down = 1'b0;
      case (mode)
         GPC_MODE_HIZ: begin
            next_oe_n = !(fn_claim_i && fn_oe_i);
            next_out  = drive_val;
         end
         GPC_MODE_PULL: begin
            next_oe_n = !(fn_claim_i && fn_oe_i);
            next_out  = drive_val;
            next_up   = !pull_sel_i || latch_i;
            next_down = pull_sel_i && !latch_i;
         end
         GPC_MODE_PP: begin
            next_oe_n = !drive_on;
            next_out  = drive_val;
         end
         GPC_MODE_OD: begin
            // Only a low is driven; a high releases the pad
            next_oe_n = !(drive_on && !drive_val);
            next_out  = 1'b0;
         end
         default: begin
            next_oe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !IMPL) begin
         pad_out_o   <= 1'b0;
         pad_oe_n_o  <= 1'b1;
         pull_up_o   <= 1'b0;
         pull_down_o <= 1'b0;
         din_o       <= 1'b0;
      end else begin
         pad_out_o   <= next_out;
         pad_oe_n_o  <= next_oe_n;
         pull_up_o   <= next_up;
         pull_down_o <= next_down;
         din_o       <= pad_in_i && !in_disable_i;
      end
   end

endmodule // gpc_pin_cell

`default_nettype wire

// File: hw/gpc_relocate.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_relocate (
   // Relocation control
   input  wire logic [gpc_pkg::RELOC_W-1:0]  reloc_i,
   // Peripheral side
   input  wire gpc_pkg::gpc_fn_drive_t       fn_drive_i,
   output logic [gpc_pkg::NUM_FN-1:0]        fn_in_o,
   // Pin side
   input  wire logic [gpc_pkg::NUM_PINS-1:0] pin_din_i,
   output logic [gpc_pkg::NUM_PINS-1:0]      claim_o,
   output logic [gpc_pkg::NUM_PINS-1:0]      pin_out_o,
   output logic [gpc_pkg::NUM_PINS-1:0]      pin_oe_o
);
   import gpc_pkg::*;

   logic [PIN_IDX_W-1:0] fn_pin [NUM_FN];

   genvar f, p;
   generate
      for (f = 0; f < NUM_FN; f++) begin : g_fn
         // Clear keeps the default pin, set takes the alternate
         assign fn_pin[f] = reloc_i[RELOC_BIT[f]] ?
                            FN_ALT_PIN[f] : FN_DEF_PIN[f];
         assign fn_in_o[f] = pin_din_i[fn_pin[f]];
      end
      for (p = 0; p < NUM_PINS; p++) begin : g_pin
         // Lowest function number wins a pin that two functions want
         always_comb begin
            claim_o[p]   = 1'b0;
            pin_out_o[p] = 1'b0;
            pin_oe_o[p]  = 1'b0;
            for (int k = NUM_FN - 1; k >= 0; k--) begin
               if (fn_drive_i.en[k] && fn_pin[k] == PIN_IDX_W'(p)) begin
                  claim_o[p]   = 1'b1;
                  pin_out_o[p] = fn_drive_i.out[k];
                  pin_oe_o[p]  = fn_drive_i.oe[k];
               end
            end
         end
      end
   endgenerate

endmodule // gpc_relocate

`default_nettype wire

// File: hw/gpc_top.sv
// Functional notes
// - Mode bits 00 hi-z input, 01 pulled input, 10 push-pull, 11 open-drain.
// - Plain port read gives pins; read-modify-write reads give the latch.
// - Pull select 0 in pulled-input mode enables the pull-up.
// - Pull select 1: latch bit 1 gives pull-up, 0 gives pull-down.
// - Input without pull ignores pull select; no resistor enabled.
// - Pull selects sit at bit 6 port 2, bit 5 port 1, bit 4 port 0.
// - Bits 3..0 of the pull register disable port 0 pins 3..0 inputs.
// - Port 1 and 2 disable registers: bit set turns off that pad input.
// - Relocate A bit 7 moves all four SPI pins together.
// - Relocate A bit 6 moves I2C clock and data.
// - Relocate A bit 5 moves UART0 receive and transmit.
// - Relocate A bits 4 and 3 move external interrupt one and zero.
// - Relocate A bit 2 moves timer two trigger input and compare output.
// - Relocate A bits 1 and 0 move timer 1 and timer 0 inputs.
// - Relocate B bit 6 moves the three channel aux outputs.
// - Relocate B bit 5 moves UART1 pins.
// - Relocate B bit 4 moves the tone output.
// - Relocate B bit 3 moves all eight keypad inputs together.
// - Relocate B bits 1 and 0 move PWM1 and PWM0 outputs.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module gpc_top (
   // Clock and reset
   input  wire logic                           ref_clk_i,
   input  wire logic                           reset_i,
   // Avalon-MM slave
   input  wire logic [gpc_pkg::ADDR_W-1:0]     avs_address_i,
   input  wire logic                           avs_read_i,
   input  wire logic                           avs_write_i,
   input  wire logic [gpc_pkg::DATA_W-1:0]     avs_writedata_i,
   input  wire logic [gpc_pkg::BE_W-1:0]       avs_byteenable_i,
   output logic [gpc_pkg::DATA_W-1:0]          avs_readdata_o,
   output logic                                avs_waitrequest_o,
   // Pads
   input  wire logic [gpc_pkg::NUM_PINS-1:0]   pad_in_i,
   output wire gpc_pkg::gpc_pads_t             pads_o,
   // Peripheral units
   input  wire gpc_pkg::gpc_fn_drive_t         fn_drive_i,
   output logic [gpc_pkg::NUM_FN-1:0]          fn_in_o
);
   import gpc_pkg::*;

   // Register file
   logic [PORT_W-1:0] latch_q   [NUM_PORTS];
   logic [PORT_W-1:0] mode_lo_q [NUM_PORTS];
   logic [PORT_W-1:0] mode_hi_q [NUM_PORTS];
   logic [PORT_W-1:0] pull_asw_q;
   logic [PORT_W-1:0] dis1_q;
   logic [PORT_W-1:0] dis2_q;
   logic [PORT_W-1:0] reloc_a_q;
   logic [PORT_W-1:0] reloc_b_q;
   logic [PORT_W-1:0] readback_q;

   // Bus decode
   wire [INDEX_W-1:0] idx      = avs_address_i[ADDR_W-1:2];
   wire               aligned  = (avs_address_i[1:0] == 2'b00);
   wire               req      = avs_read_i || avs_write_i;
   wire               next_wait = !(req && avs_waitrequest_o);
   // Write lands on the edge where waitrequest is seen low
   wire               wr_go    = avs_write_i && !avs_waitrequest_o &&
                                 avs_byteenable_i[0] && aligned;
   wire               rd_load  = avs_read_i && avs_waitrequest_o;
   wire [PORT_W-1:0]  wdata    = avs_writedata_i[PORT_W-1:0];

   wire we_pull_asw = wr_go && (idx == IDX_PULL_ASW);
   wire we_dis1     = wr_go && (idx == IDX_DIS1);
   wire we_dis2     = wr_go && (idx == IDX_DIS2);
   wire we_reloc_a  = wr_go && (idx == IDX_RELOC_A);
   wire we_reloc_b  = wr_go && (idx == IDX_RELOC_B);
   wire we_readback = wr_go && (idx == IDX_READBACK);

   // Pin-level wiring
   logic [NUM_PINS-1:0] pin_din;
   logic [NUM_PINS-1:0] claim;
   logic [NUM_PINS-1:0] fn_out;
   logic [NUM_PINS-1:0] fn_oe;
   logic [NUM_PINS-1:0] cell_out;
   logic [NUM_PINS-1:0] cell_oe_n;
   logic [NUM_PINS-1:0] cell_up;
   logic [NUM_PINS-1:0] cell_down;
   logic [NUM_FN-1:0]   fn_in_w;

   // Per-port register access and read values
   logic [PORT_W-1:0] port_rd  [NUM_PORTS];
   logic [PORT_W-1:0] lo_rd    [NUM_PORTS];
   logic [PORT_W-1:0] hi_rd    [NUM_PORTS];
   logic [NUM_PORTS-1:0] hit_latch;
   logic [NUM_PORTS-1:0] hit_lo;
   logic [NUM_PORTS-1:0] hit_hi;

   genvar gp, gi;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         assign hit_latch[gp] = (idx == IDX_LATCH[gp]);
         assign hit_lo[gp]    = (idx == IDX_MODE_LO[gp]);
         assign hit_hi[gp]    = (idx == IDX_MODE_HI[gp]);
         // Readback bit set marks the read as read-modify-write
         assign port_rd[gp] = readback_q[gp] ? latch_q[gp] :
                              pin_din[gp*PORT_W +: PORT_W] &
                              IMPL_MASK[gp];
         assign lo_rd[gp] = hit_lo[gp] ? mode_lo_q[gp] : REG_RESET;
         assign hi_rd[gp] = hit_hi[gp] ? mode_hi_q[gp] : REG_RESET;

         always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
               latch_q[gp]   <= REG_RESET;
               mode_lo_q[gp] <= REG_RESET;
               mode_hi_q[gp] <= REG_RESET;
            end else begin
               // Unimplemented port 0 bits stay zero
               if (wr_go && hit_latch[gp]) begin
                  latch_q[gp] <= wdata & IMPL_MASK[gp];
               end
               if (wr_go && hit_lo[gp]) begin
                  mode_lo_q[gp] <= wdata & IMPL_MASK[gp];
               end
               if (wr_go && hit_hi[gp]) begin
                  mode_hi_q[gp] <= wdata & IMPL_MASK[gp];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pull_asw_q <= REG_RESET;
         dis1_q     <= REG_RESET;
         dis2_q     <= REG_RESET;
         reloc_a_q  <= REG_RESET;
         reloc_b_q  <= REG_RESET;
         readback_q <= REG_RESET;
      end else begin
         if (we_pull_asw) begin
            pull_asw_q <= wdata & PULL_ASW_MASK;
         end
         if (we_dis1) begin
            dis1_q <= wdata;
         end
         if (we_dis2) begin
            dis2_q <= wdata;
         end
         if (we_reloc_a) begin
            reloc_a_q <= wdata;
         end
         if (we_reloc_b) begin
            // Reserved bits kept as written; software leaves them zero
            reloc_b_q <= wdata;
         end
         if (we_readback) begin
            readback_q <= wdata & READBACK_MASK;
         end
      end
   end

   // Read mux; unmapped or misaligned addresses read zero
   wire [PORT_W-1:0] rd_ports =
      (hit_latch[0] ? port_rd[0] : REG_RESET) |
      (hit_latch[1] ? port_rd[1] : REG_RESET) |
      (hit_latch[2] ? port_rd[2] : REG_RESET) |
      lo_rd[0] | lo_rd[1] | lo_rd[2] |
      hi_rd[0] | hi_rd[1] | hi_rd[2];
   wire [PORT_W-1:0] rd_misc =
      ((idx == IDX_PULL_ASW) ? pull_asw_q : REG_RESET) |
      ((idx == IDX_DIS1)     ? dis1_q     : REG_RESET) |
      ((idx == IDX_DIS2)     ? dis2_q     : REG_RESET) |
      ((idx == IDX_RELOC_A)  ? reloc_a_q  : REG_RESET) |
      ((idx == IDX_RELOC_B)  ? reloc_b_q  : REG_RESET) |
      ((idx == IDX_READBACK) ? readback_q : REG_RESET);
   wire [PORT_W-1:0] rd_byte = aligned ? (rd_ports | rd_misc) : REG_RESET;

   // Fixed two-cycle answer: waitrequest drops one cycle after the request
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= RDATA_RESET;
      end else begin
         avs_waitrequest_o <= next_wait;
         if (rd_load) begin
            avs_readdata_o <= {{(DATA_W-PORT_W){1'b0}}, rd_byte};
         end
      end
   end

   // Peripheral pin relocation
   gpc_relocate u_relocate (
      .reloc_i    ({reloc_b_q, reloc_a_q}),
      .fn_drive_i (fn_drive_i),
      .fn_in_o    (fn_in_w),
      .pin_din_i  (pin_din),
      .claim_o    (claim),
      .pin_out_o  (fn_out),
      .pin_oe_o   (fn_oe)
   );

   // Registered so peripherals see no combinational path from the pads
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fn_in_o <= '0;
      end else begin
         fn_in_o <= fn_in_w;
      end
   end

   // Pin cells
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_cell
         localparam int PRT = gi / PORT_W;
         localparam int BT  = gi % PORT_W;
         logic in_dis;
         if (PRT == 0) begin : g_dis0
            if (BT < ASW0_BITS) begin : g_sw
               assign in_dis = pull_asw_q[BT];
            end else begin : g_nosw
               assign in_dis = 1'b0;
            end
         end else if (PRT == 1) begin : g_dis1
            assign in_dis = dis1_q[BT];
         end else begin : g_dis2
            assign in_dis = dis2_q[BT];
         end

         gpc_pin_cell #(
            .IMPL (IMPL_MASK[PRT][BT])
         ) u_cell (
            .ref_clk_i    (ref_clk_i),
            .reset_i      (reset_i),
            .mode_bits_i  ({mode_lo_q[PRT][BT], mode_hi_q[PRT][BT]}),
            .latch_i      (latch_q[PRT][BT]),
            .pull_sel_i   (pull_asw_q[PULL_SEL_BIT[PRT]]),
            .in_disable_i (in_dis),
            .fn_claim_i   (claim[gi]),
            .fn_out_i     (fn_out[gi]),
            .fn_oe_i      (fn_oe[gi]),
            .pad_in_i     (pad_in_i[gi]),
            .pad_out_o    (cell_out[gi]),
            .pad_oe_n_o   (cell_oe_n[gi]),
            .pull_up_o    (cell_up[gi]),
            .pull_down_o  (cell_down[gi]),
            .din_o        (pin_din[gi])
         );
      end
   endgenerate

   assign pads_o = '{dout:      cell_out,
                     oe_n:      cell_oe_n,
                     pull_up:   cell_up,
                     pull_down: cell_down};

endmodule // gpc_top

`default_nettype wire

// File: inc/gpc_pkg.sv
package gpc_pkg;

   // Geometry
   localparam int NUM_PORTS = 3;
   localparam int PORT_W    = 8;
   localparam int NUM_PINS  = NUM_PORTS * PORT_W;
   localparam int PIN_IDX_W = 5;
   localparam int NUM_FN    = 30;
   localparam int RELOC_W   = 16;

   // Avalon-MM slave geometry
   localparam int ADDR_W  = 10;
   localparam int DATA_W  = 32;
   localparam int BE_W    = 4;
   localparam int INDEX_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [INDEX_W-1:0] IDX_LATCH [NUM_PORTS] =
      '{8'h80, 8'h90, 8'ha0};
   localparam logic [INDEX_W-1:0] IDX_MODE_LO [NUM_PORTS] =
      '{8'ha1, 8'ha3, 8'ha5};
   localparam logic [INDEX_W-1:0] IDX_MODE_HI [NUM_PORTS] =
      '{8'ha2, 8'ha4, 8'ha6};
   localparam logic [INDEX_W-1:0] IDX_PULL_ASW  = 8'hab;
   localparam logic [INDEX_W-1:0] IDX_DIS1      = 8'hac;
   localparam logic [INDEX_W-1:0] IDX_DIS2      = 8'had;
   localparam logic [INDEX_W-1:0] IDX_RELOC_A   = 8'hae;
   localparam logic [INDEX_W-1:0] IDX_RELOC_B   = 8'haf;
   localparam logic [INDEX_W-1:0] IDX_READBACK  = 8'hb0;

   // Field layout and reset values
   localparam logic [PORT_W-1:0] IMPL_MASK [NUM_PORTS] =
      '{8'h3f, 8'hff, 8'hff};
   localparam logic [PORT_W-1:0] PULL_ASW_MASK = 8'h7f;
   localparam logic [PORT_W-1:0] READBACK_MASK = 8'h07;
   localparam int PULL_SEL_BIT [NUM_PORTS] = '{4, 5, 6};
   localparam int ASW0_BITS = 4;
   localparam logic [PORT_W-1:0] REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

   // Mode bit pairs {mode_select_low, mode_select_high}
   localparam logic [1:0] MODE_BITS_HIZ  = 2'b00;
   localparam logic [1:0] MODE_BITS_PULL = 2'b01;
   localparam logic [1:0] MODE_BITS_PP   = 2'b10;
   localparam logic [1:0] MODE_BITS_OD   = 2'b11;

   typedef enum logic [3:0] {
      GPC_MODE_HIZ  = 4'b0001,
      GPC_MODE_PULL = 4'b0010,
      GPC_MODE_PP   = 4'b0100,
      GPC_MODE_OD   = 4'b1000
   } gpc_mode_t;

   // Relocation bit per function, index into {pin_relocate_b, pin_relocate_a}
   localparam int RELOC_BIT [NUM_FN] = '{
      7, 7, 7, 7,                // SPI select, clock, miso, mosi
      6, 6,                      // I2C clock, data
      5, 5,                      // UART0 rx, tx
      4, 3,                      // ext interrupt one, zero
      2, 2,                      // timer two trigger, compare
      1, 0,                      // timer 1, timer 0 count inputs
      14, 14, 14,                // three channel aux output
      13, 13,                    // UART1 rx, tx
      12,                        // tone output
      11, 11, 11, 11, 11, 11, 11, 11, // keypad inputs 0..7
      9, 8                       // PWM1, PWM0
   };
   // Pin index = port * 8 + bit
   localparam logic [PIN_IDX_W-1:0] FN_DEF_PIN [NUM_FN] = '{
      5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
      5'h03, 5'h02, 5'h00, 5'h01, 5'h04, 5'h05,
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
      5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
      5'h16, 5'h17
   };
   localparam logic [PIN_IDX_W-1:0] FN_ALT_PIN [NUM_FN] = '{
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
      5'h05, 5'h04, 5'h16, 5'h17, 5'h11, 5'h10,
      5'h00, 5'h01, 5'h02, 5'h0a, 5'h0b, 5'h03,
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
      5'h0d, 5'h0c
   };

   typedef struct packed {
      logic [NUM_PINS-1:0] dout;
      logic [NUM_PINS-1:0] oe_n;
      logic [NUM_PINS-1:0] pull_up;
      logic [NUM_PINS-1:0] pull_down;
   } gpc_pads_t;

   typedef struct packed {
      logic [NUM_FN-1:0] en;
      logic [NUM_FN-1:0] out;
      logic [NUM_FN-1:0] oe;
   } gpc_fn_drive_t;

endpackage

// File: test/gpc_checker.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_checker (
   // Clock and reset
   input wire logic                       ref_clk_i,
   input wire logic                       reset_i,
   // Register bus
   input wire logic [gpc_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic                       avs_read_i,
   input wire logic                       avs_write_i,
   input wire logic [gpc_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic                       avs_waitrequest_o,
   // Pads and functions
   input wire gpc_pkg::gpc_pads_t         pads_o,
   input wire logic [gpc_pkg::NUM_FN-1:0] fn_in_o
);
   import gpc_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   wire       req = avs_read_i | avs_write_i;
   wire [7:0] idx = avs_address_i[9:2];
   // Coarse decode only; gaps inside the map are not covered
   wire       unmapped = (idx < 8'h80) || (idx > 8'hb0)
                         || (avs_address_i[1:0] != 2'b00);
   sequence s_take;
      req && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   access_wait_a: assert property (s_take |=> s_answer)
      else $error("access did not answer after one wait state");
   idle_wait_a: assert property (!req && avs_waitrequest_o
      |=> avs_waitrequest_o)
      else $error("waitrequest dropped with no request");
   rdata_upper_a: assert property (avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   unmapped_read_a: assert property (avs_read_i
      && !avs_waitrequest_o && unmapped |-> avs_readdata_o == 32'h0)
      else $error("unmapped read returned nonzero");
   rdata_hold_a: assert property (!avs_read_i
      |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   port0_released_a: assert property (pads_o.oe_n[7:6] == 2'b11)
      else $error("unimplemented port 0 pins driven");
   pull_exclusive_a: assert property (
      (pads_o.pull_up & pads_o.pull_down) == 24'h0)
      else $error("pull-up and pull-down on together");
   reset_quiet_a: assert property ($fell(reset_i)
      |-> avs_waitrequest_o && pads_o.oe_n == 24'hffffff
      && pads_o.pull_up == 24'h0 && pads_o.pull_down == 24'h0
      && fn_in_o == 30'h0)
      else $error("state after reset not idle");
endmodule // gpc_checker

bind gpc_top gpc_checker u_chk (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .pads_o(pads_o), .fn_in_o(fn_in_o)
);

`default_nettype wire

// File: test/gpc_pad_model.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_pad_model (
   // Pads from the block
   input  wire gpc_pkg::gpc_pads_t           pads_i,
   // Weak far-side source on released pins
   input  wire logic [gpc_pkg::NUM_PINS-1:0] ext_i,
   // Resolved pad levels
   output logic [gpc_pkg::NUM_PINS-1:0]      level_o
);
   import gpc_pkg::*;
   wire [NUM_PINS-1:0] pulled = pads_i.pull_up | pads_i.pull_down;
   // Block drive wins, then the resistor, then the weak outside source
   assign level_o = (~pads_i.oe_n & pads_i.dout)
                  | (pads_i.oe_n & pulled & pads_i.pull_up)
                  | (pads_i.oe_n & ~pulled & ext_i);
endmodule // gpc_pad_model

`default_nettype wire

// File: test/gpc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module gpc_top_bench;
   import gpc_pkg::*;
   logic                clk;
   logic                reset;
   logic [ADDR_W-1:0]   address;
   logic                read;
   logic                write;
   logic [DATA_W-1:0]   wdata;
   logic [BE_W-1:0]     be;
   logic [NUM_PINS-1:0] ext;
   gpc_fn_drive_t       fn_drive;
   wire  [DATA_W-1:0]   rdata;
   wire                 waitreq;
   wire  [NUM_PINS-1:0] pad_level;
   wire  gpc_pads_t     pads;
   wire  [NUM_FN-1:0]   fn_in;
   int                  mismatches;
   int                  checks_done;
   int                  b;
   logic [15:0]         sel;
   logic [4:0]          p;
   logic [DATA_W-1:0]   rv;
   logic [23:0]         pin_bit;
   // Index, write value, expected readback
   logic [23:0] rows [16] = '{24'hb0_07_07, 24'h80_ff_3f, 24'ha1_ff_3f,
      24'ha2_c3_03, 24'h90_5a_5a, 24'ha0_a5_a5, 24'ha3_3c_3c, 24'ha4_c3_c3,
      24'ha5_69_69, 24'ha6_96_96, 24'hab_ff_7f, 24'hac_81_81, 24'had_18_18,
      24'hae_96_96, 24'haf_7b_7b, 24'h3f_ff_00};

   gpc_top DUT (.ref_clk_i(clk), .reset_i(reset), .avs_address_i(address),
      .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .pad_in_i(pad_level), .pads_o(pads),
      .fn_drive_i(fn_drive), .fn_in_o(fn_in));
   gpc_pad_model u_pads (.pads_i(pads), .ext_i(ext), .level_o(pad_level));

   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk);
      address <= {idx, 2'b00};
      read    <= ~wr;
      write   <= wr;
      wdata   <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 64);
      if (n >= 64) mismatches++;
      rv = rdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task wreg(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask

   task rchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rv, {56'h0, exp});
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task clear_all;
      for (int i = 0; i < 16; i++) wreg(rows[i][23:16], 8'h00);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      reset = 1'b1;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      wdata = '0;
      be = 4'hf;
      ext = '0;
      fn_drive = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         rchk(rows[i][23:16], 8'h00);
         wreg(rows[i][23:16], rows[i][15:8]);
         rchk(rows[i][23:16], rows[i][7:0]);
      end
      clear_all();
      // Port 1 pairs: 7,6 open-drain; 5,4 push-pull; 3,2 pulled; 1,0 hi-z
      wreg(8'ha3, 8'hf0);
      wreg(8'ha4, 8'hcc);
      wreg(8'h90, 8'haa);
      tick(4);
      // Released input pins still carry the latch on dout
      chk({pads.oe_n[15:8], pads.dout[15:8], pads.pull_up[15:8],
           pads.pull_down[15:8]}, 64'h8f2a_0c00);
      wreg(8'hab, 8'h20);
      tick(4);
      chk({pads.oe_n[15:8], pads.dout[15:8], pads.pull_up[15:8],
           pads.pull_down[15:8]}, 64'h8f2a_0804);
      rchk(8'h90, 8'h28);
      wreg(8'hac, 8'h08);
      rchk(8'h90, 8'h20);
      wreg(8'hb0, 8'h02);
      rchk(8'h90, 8'haa);
      wreg(8'hb0, 8'h00);
      wreg(8'ha2, 8'h01);
      tick(4);
      rchk(8'h80, 8'h01);
      wreg(8'hab, 8'h21);
      rchk(8'h80, 8'h00);
      wreg(8'hab, 8'h10);
      tick(4);
      chk(pads.pull_down[0], 64'h1);
      clear_all();
      // One function at a time, so no claim collisions
      for (int f = 0; f < NUM_FN; f++) begin
         fn_drive <= {3{30'h1 << f}};
         for (int alt = 0; alt < 2; alt++) begin
            b = RELOC_BIT[f];
            sel = (alt == 1) ? (16'h1 << b) : 16'h0;
            wreg(8'hae, sel[7:0]);
            wreg(8'haf, sel[15:8]);
            tick(6);
            p = (alt == 1) ? FN_ALT_PIN[f] : FN_DEF_PIN[f];
            pin_bit = 24'h1 << p;
            chk(fn_in[f], 64'h1);
            chk({~pads.oe_n, pads.dout}, {pin_bit, pin_bit});
         end
      end
      fn_drive <= '0;
      tick(2);
      // Released pins without pull follow the outside level
      ext <= '1;
      tick(4);
      rchk(8'ha0, 8'hff);
      rchk(8'h80, 8'h3f);
      wreg(8'hab, 8'h55);
      rchk(8'h80, 8'h3a);
      // Mid-run reset must clear the registers again; pull, relocate B and the port 0 pin read are checked
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      rchk(8'hab, 8'h00);
      rchk(8'haf, 8'h00);
      rchk(8'h80, 8'h3f);
      print_verdict();
   end
endmodule // gpc_top_bench

`default_nettype wire
